// *** potsa_pkg.sv ***
// Summary of operation
// - Acknowledge write bytes; stop returns to idle.
// - Store each volatile write byte, then advance pointer; stored writes keep the last byte.
// - Write pointer wraps from top to zero.
// - Non-volatile programming starts only after stop.
// - Acknowledge all three read instruction bytes.
// - Keep sending bytes while controller acknowledges.
// - Read pointer loads from address, increments per byte.
// - Read pointer wraps to zero, continues sending.
// - Id byte: fixed prefix, pin match, direction bit.
// - Control register top bit selects volatile or stored.
// - Reject wiper and control writes while busy.
// - Addresses zero to three select pots zero to three.
package potsa_pkg;

  // ****************************************************************
  // Register map and field positions.
  // ****************************************************************
  localparam logic [7:0] POTSA_ADDR_TOP     = 8'h08;  // Highest location, holds the access control register.
  localparam logic [7:0] POTSA_ADDR_ACR     = 8'h08;  // Access control register location.
  localparam logic [7:0] POTSA_ADDR_GP_LAST = 8'h06;  // Last general purpose location.
  localparam logic [7:0] POTSA_ADDR_POT_LAST = 8'h03; // Last potentiometer location.
  localparam int         POTSA_VOL_BIT      = 7;      // Volatile select bit position.
  localparam int         POTSA_SHDN_BIT     = 6;      // Shutdown control bit position.
  localparam int         POTSA_WIP_BIT      = 5;      // Write in progress bit position.
  localparam int         POTSA_NUM_POTS     = 4;      // Number of potentiometers.
  localparam int         POTSA_NUM_NV       = 7;      // Number of non-volatile locations.

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] POTSA_WIPER_RST    = 8'h40;  // Wiper value at power up.
  localparam logic [7:0] POTSA_NV_RST       = 8'h40;  // Stored value before any programming.
  localparam logic       POTSA_VOL_RST      = 1'h0;   // Volatile select after reset.
  localparam logic       POTSA_SHDN_RST     = 1'h1;   // Shutdown bit after reset.

  // ****************************************************************
  // Identification byte.
  // ****************************************************************
  localparam logic [3:0] POTSA_ID_PREFIX    = 4'h5;   // Fixed prefix, value arbitrary.

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int POTSA_CLK_MHZ    = 125;              // Clock rate in MHz.
  localparam int POTSA_NV_WR_MS   = 20;               // Programming time in ms.
  localparam int POTSA_NV_WR_CYC  = POTSA_NV_WR_MS * 1000 * POTSA_CLK_MHZ; // Programming cycles.
  localparam int POTSA_FIFO_DEPTH = 8;                // Write data FIFO depth.

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  // One received write byte with its target location.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } potsa_wr_s;

endpackage

// *** potsa_fifo.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Synchronous FIFO with valid and ready on both sides.
// ****************************************************************
module potsa_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage array.
  logic [AW-1:0]    wr_ptr_q;       // Write index.
  logic [AW-1:0]    rd_ptr_q;       // Read index.
  logic [AW:0]      count_q;        // Number of words held.
  wire              push;           // Word accepted this cycle.
  wire              pop;            // Word removed this cycle.

  // Ready while at least one slot is free, including when empty.
  assign in_ready_o  = (count_q < (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write; no reset needed for the data array.
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** potsa_core.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Two-wire target transaction logic of a quad digital pot.
// ****************************************************************
module potsa_core #(
  parameter int NV_WR_CYC = potsa_pkg::POTSA_NV_WR_CYC
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // Bus pins, sampled as synchronous inputs.
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Address select straps.
  input  wire logic        addr_select_pin_2_i,
  input  wire logic        addr_select_pin_1_i,
  input  wire logic        addr_select_pin_0_i,
  // Potentiometer state.
  output logic [31:0]      wiper_o,
  output logic             shutdown_bit_o,
  output logic             write_in_progress_flag_o
);
  // ****************************************************************
  // Declarations.
  // ****************************************************************
  typedef enum logic [2:0] {S_IDLE, S_ID, S_ADDR, S_WDATA, S_RDATA, S_IGNORE} potsa_state_e;

  potsa_state_e state_q;                 // Transaction phase.
  logic         scl_q;                   // Previous clock level.
  logic         sda_q;                   // Previous data level.
  logic [7:0]   shift_q;                 // Receive and transmit shifter.
  logic [3:0]   bit_q;                   // Bit count within a byte, 8 means the ack slot.
  logic         ack_slot_q;              // Device drives ack in this slot.
  logic         rd_mode_q;               // Current byte slot is a read data byte.
  logic [7:0]   ptr_q;                   // Internal register pointer.
  logic [7:0]   wiper_q [4];             // Volatile wiper registers.
  logic [7:0]   nv_q [7];                // Initial value and general purpose store.
  logic [7:0]   access_control_reg_q;    // Volatile select and shutdown bits.
  logic         wip_q;                   // Programming busy flag.
  logic [31:0]  wip_cnt_q;               // Programming delay counter.
  logic         nv_pend_q;               // A stored write waits for the stop.
  logic [7:0]   nv_addr_q;               // Pending stored location.
  logic [7:0]   nv_data_q;               // Pending stored value.
  logic         sda_q_o;                 // Output data register.
  logic         sda_oe_q;                // Output enable register.

  // Edge and condition decode.
  wire          scl_rise   = scl_i && !scl_q;
  wire          scl_fall   = !scl_i && scl_q;
  wire          start_det  = scl_i && scl_q && sda_q && !sda_i;
  wire          stop_det   = scl_i && scl_q && !sda_q && sda_i;
  wire [7:0]    rx_byte    = {shift_q[6:0], sda_i};
  wire          byte_done  = scl_rise && (bit_q == 4'h7);
  wire          id_match   = rx_byte[7:4] == potsa_pkg::POTSA_ID_PREFIX &&
                             rx_byte[3:1] == {addr_select_pin_2_i, addr_select_pin_1_i,
                                              addr_select_pin_0_i};
  wire [7:0]    ptr_inc    = (ptr_q >= potsa_pkg::POTSA_ADDR_TOP) ? 8'h00 : ptr_q + 8'h01;
  wire          vol_sel    = access_control_reg_q[potsa_pkg::POTSA_VOL_BIT];
  wire          tgt_pot    = ptr_q <= potsa_pkg::POTSA_ADDR_POT_LAST;
  wire          tgt_gp     = ptr_q > potsa_pkg::POTSA_ADDR_POT_LAST && ptr_q <= potsa_pkg::POTSA_ADDR_GP_LAST;
  wire          tgt_acr    = ptr_q == potsa_pkg::POTSA_ADDR_ACR;
  wire [7:0]    acr_view   = {access_control_reg_q[7:6], wip_q, 5'h00};
  wire [7:0]    rd_value   = tgt_acr ? acr_view :
                             tgt_pot ? (vol_sel ? wiper_q[ptr_q[1:0]] : nv_q[ptr_q[2:0]]) :
                             tgt_gp  ? nv_q[ptr_q[2:0]] : 8'h00;
  wire          wr_byte    = state_q == S_WDATA && byte_done;
  wire          wr_allowed = !wip_q;
  wire          nv_target  = (tgt_pot && !vol_sel) || tgt_gp;

  // Write byte FIFO signals.
  potsa_pkg::potsa_wr_s fifo_in;
  potsa_pkg::potsa_wr_s fifo_out;
  wire          fifo_in_ready;
  wire          fifo_out_valid;
  wire          fifo_pop = fifo_out_valid;
  assign fifo_in.addr = ptr_q;
  assign fifo_in.data = rx_byte;

  // ****************************************************************
  // Write path buffering.
  // ****************************************************************
  potsa_fifo #(
    .WIDTH ($bits(potsa_pkg::potsa_wr_s)),
    .DEPTH (potsa_pkg::POTSA_FIFO_DEPTH)
  ) potsa_fifo_inst (
    .clk_i       (ref_clk_i),
    .rst_i       (sys_rst_i),
    .in_valid_i  (wr_byte && wr_allowed && !nv_target),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out)
  );

  // ****************************************************************
  // Bus sequencing.
  // ****************************************************************
  // Tracks bytes, acknowledge slots and the transaction phase.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q    <= S_IDLE;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      shift_q    <= 8'h00;
      bit_q      <= 4'h0;
      ack_slot_q <= 1'b0;
      rd_mode_q  <= 1'b0;
      ptr_q      <= 8'h00;
      sda_q_o    <= 1'b1;
      sda_oe_q   <= 1'b0;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (start_det)
      begin
        // A start or repeated start always restarts the id phase.
        state_q   <= S_ID;
        bit_q     <= 4'h0;
        sda_oe_q  <= 1'b0;
        rd_mode_q <= 1'b0;
      end
      else if (stop_det)
      begin
        state_q   <= S_IDLE;
        sda_oe_q  <= 1'b0;
        rd_mode_q <= 1'b0;
      end
      else if (state_q != S_IDLE && state_q != S_IGNORE)
      begin
        if (scl_rise && bit_q < 4'h8)
        begin
          shift_q <= rx_byte;
          bit_q   <= bit_q + 4'h1;
          if (bit_q == 4'h7)
          begin
            // Byte complete: decide the ack slot and next phase.
            ack_slot_q <= 1'b1;
            case (state_q)
              S_ID:
              begin
                if (!id_match)
                begin
                  // Not addressed: stay silent until the next start.
                  state_q    <= S_IGNORE;
                  ack_slot_q <= 1'b0;
                end
                else if (rx_byte[0])
                begin
                  // Read direction: data bytes follow the ack.
                  state_q <= S_RDATA;
                end
                else
                begin
                  // Write direction: the address byte comes next.
                  state_q <= S_ADDR;
                end
              end
              S_ADDR:
              begin
                // The address byte loads the pointer for both directions.
                ptr_q   <= rx_byte;
                state_q <= S_WDATA;
              end
              S_WDATA:
              begin
                // The byte goes to the write path, then the pointer moves on.
                ptr_q <= ptr_inc;
              end
              S_RDATA:
              begin
                // The controller answers read bytes, so the device stays off the line.
                ack_slot_q <= 1'b0;
              end
              default:
              begin
                state_q <= S_IGNORE;
              end
            endcase
          end
        end
        else if (scl_rise && bit_q == 4'h8)
        begin
          // Controller ack on a read byte decides continuation.
          bit_q <= 4'h0;
          if (rd_mode_q && sda_i)
          begin
            state_q <= S_IGNORE;
          end
          if (rd_mode_q)
          begin
            ptr_q <= ptr_inc;
          end
        end
        else if (scl_fall)
        begin
          if (bit_q == 4'h8 && ack_slot_q)
          begin
            sda_q_o    <= 1'b0;
            sda_oe_q   <= 1'b1;
            ack_slot_q <= 1'b0;
          end
          else if (state_q == S_RDATA && bit_q == 4'h0)
          begin
            // Load the whole byte; each rising edge then brings the next bit to the top.
            shift_q   <= rd_value;
            sda_q_o   <= rd_value[7];
            sda_oe_q  <= !rd_value[7];
            rd_mode_q <= 1'b1;
          end
          else if (state_q == S_RDATA && rd_mode_q && bit_q < 4'h8)
          begin
            // The rising edge has already shifted, so the top bit is the next one out.
            sda_q_o  <= shift_q[7];
            sda_oe_q <= !shift_q[7];
          end
          else
          begin
            sda_oe_q <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Register file and non-volatile programming.
  // ****************************************************************
  // Applies buffered write bytes and sequences programming.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < potsa_pkg::POTSA_NUM_POTS; i++) wiper_q[i] <= potsa_pkg::POTSA_WIPER_RST;
      for (int i = 0; i < potsa_pkg::POTSA_NUM_NV; i++) nv_q[i] <= potsa_pkg::POTSA_NV_RST;
      access_control_reg_q <= {potsa_pkg::POTSA_VOL_RST, potsa_pkg::POTSA_SHDN_RST, 6'h00};
      wip_q     <= 1'b0;
      wip_cnt_q <= 32'h0;
      nv_pend_q <= 1'b0;
      nv_addr_q <= 8'h00;
      nv_data_q <= 8'h00;
    end
    else
    begin
      // Buffered volatile writes land here unless programming is busy.
      if (fifo_pop && !wip_q)
      begin
        if (fifo_out.addr == potsa_pkg::POTSA_ADDR_ACR)
        begin
          access_control_reg_q <= {fifo_out.data[7:6], 6'h00};
        end
        else if (fifo_out.addr <= potsa_pkg::POTSA_ADDR_POT_LAST)
        begin
          wiper_q[fifo_out.addr[1:0]] <= fifo_out.data;
        end
      end
      // A stored write only parks its byte until the closing stop arrives.
      if (wr_byte && nv_target && !wip_q)
      begin
        nv_pend_q <= 1'b1;
        nv_addr_q <= ptr_q;
        nv_data_q <= rx_byte;
      end
      if (stop_det && nv_pend_q)
      begin
        // Programming begins only once the closing stop is seen.
        nv_pend_q              <= 1'b0;
        nv_q[nv_addr_q[2:0]]   <= nv_data_q;
        if (nv_addr_q <= potsa_pkg::POTSA_ADDR_POT_LAST)
        begin
          wiper_q[nv_addr_q[1:0]] <= nv_data_q;
        end
        wip_q     <= 1'b1;
        wip_cnt_q <= 32'(NV_WR_CYC);
      end
      else if (wip_q)
      begin
        // Count down the programming delay; bus traffic does not pause it.
        wip_cnt_q <= wip_cnt_q - 32'h1;
        if (wip_cnt_q == 32'h1)
        begin
          wip_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  for (genvar g = 0; g < potsa_pkg::POTSA_NUM_POTS; g++)
  begin : g_wiper
    assign wiper_o[8*g +: 8] = wiper_q[g];
  end
  assign sda_o                    = sda_q_o;
  assign sda_oe_o                 = sda_oe_q;
  assign shutdown_bit_o           = access_control_reg_q[potsa_pkg::POTSA_SHDN_BIT];
  assign write_in_progress_flag_o = wip_q;
endmodule

// *** potsa_core_props.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Port checker of the serial access core.
// ****************************************************************
module potsa_core_props #(
  parameter int NV_WR_CYC = potsa_pkg::POTSA_NV_WR_CYC
) (
  // Clock and reset.
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  // Bus and straps.
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        addr_select_pin_2_i,
  input wire logic        addr_select_pin_1_i,
  input wire logic        addr_select_pin_0_i,
  // Pot state.
  input wire logic [31:0] wiper_o,
  input wire logic        shutdown_bit_o,
  input wire logic        write_in_progress_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [31:0] busy_n_q;  // Cycles the busy flag has stood high.
  logic [7:0]  idle_n_q;  // Cycles since the last stop, saturating.
  logic        scl_q;     // Bus clock one sample back.
  logic        sda_q;     // Bus data one sample back.
  logic        stop_seen; // Data rose while the bus clock stayed high.
  assign stop_seen = scl_i & scl_q & sda_i & ~sda_q;
  // Saturation keeps an old stop from looking recent after a wrap.
  always_ff @(posedge ref_clk_i)
  begin
    scl_q    <= scl_i;
    sda_q    <= sda_i;
    busy_n_q <= (sys_rst_i | ~write_in_progress_flag_o) ? 32'h0 : busy_n_q + 32'h1;
    idle_n_q <= sys_rst_i ? 8'hFF : stop_seen ? 8'h00 : idle_n_q + {7'h00, ~&idle_n_q};
  end
  reset_state_a : assert property (
    $past(sys_rst_i) |-> !sda_oe_o && !write_in_progress_flag_o && shutdown_bit_o)
    else $error("Core left reset in a wrong state.");
  drive_low_a : assert property (
    sda_oe_o |-> !sda_o) else $error("Data driven high.");
  oe_scl_low_a : assert property (
    $changed(sda_oe_o) |-> !scl_i) else $error("Data enable moved with clock high.");
  oe_bounded_a : assert property (
    $rose(sda_oe_o) |-> ##[1:400] !sda_oe_o) else $error("Data line held too long.");
  busy_len_a : assert property (
    $fell(write_in_progress_flag_o) |-> busy_n_q == NV_WR_CYC) else $error("Busy time wrong.");
  busy_cap_a : assert property (
    busy_n_q <= NV_WR_CYC) else $error("Busy flag stuck.");
  busy_after_stop_a : assert property (
    $rose(write_in_progress_flag_o) |-> idle_n_q < 8'd16) else $error("Programming without stop.");
  busy_hold_a : assert property (
    write_in_progress_flag_o && $past(write_in_progress_flag_o, 4) |-> $stable(wiper_o) && $stable(shutdown_bit_o))
    else $error("State changed while busy.");
  // Main scenarios reached.
  cover property ($rose(write_in_progress_flag_o));
  cover property ($fell(write_in_progress_flag_o));
  cover property ($rose(sda_oe_o));
endmodule
bind potsa_core potsa_core_props #(.NV_WR_CYC(NV_WR_CYC)) potsa_core_props_inst (.ref_clk_i, .sys_rst_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_o, .addr_select_pin_2_i, .addr_select_pin_1_i, .addr_select_pin_0_i, .wiper_o,
  .shutdown_bit_o, .write_in_progress_flag_o);

// *** potsa_ctrl_model.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Behavioural bus controller; the clock idles high between frames.
// ****************************************************************
module potsa_ctrl_model #(
  parameter int HALF = 10
) (
  // Clock and bus.
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic     scl_o,
  output logic     sda_pull_o
);
  logic [7:0] rx_q;    // Byte seen on the wire.
  logic       ak_q;    // Level in the ninth slot.
  event       done_ev; // One byte finished.
  initial scl_o = 1'b1;
  initial sda_pull_o = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Data moves only while the clock is low, away from its edges.
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_pull_o = ~b;
    tick(HALF - 2);
    scl_o = 1'b1;
    tick(HALF / 2);
    r = sda_i;
    tick(HALF - HALF / 2);
    scl_o = 1'b0;
  endtask
  // Eight bits first from the top, then the acknowledge slot.
  task automatic byte_x(input logic [7:0] tx, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_x(tx[i], rx_q[i]);
    bit_x(last, ak_q);
    -> done_ev;
  endtask
  task automatic start_c();
    sda_pull_o = 1'b1;
    tick(HALF);
    scl_o = 1'b0;
  endtask
  task automatic restart_c();
    tick(2);
    sda_pull_o = 1'b0;
    tick(HALF - 2);
    scl_o = 1'b1;
    tick(HALF);
    start_c();
  endtask
  task automatic stop_c();
    tick(2);
    sda_pull_o = 1'b1;
    tick(HALF - 2);
    scl_o = 1'b1;
    tick(HALF);
    sda_pull_o = 1'b0;
    tick(HALF);
  endtask
endmodule

// *** potsa_core_bench.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench of the serial access core.
// ****************************************************************
module potsa_core_bench;
  localparam int NV = 4000;
  logic        ref_clk_i;
  logic        sys_rst_i;
  logic        scl;
  logic        sda;      // Wire level with pull-up.
  logic        sda_pull;
  logic        sda_o;
  logic        sda_oe_o;
  logic [2:0]  pins;
  logic [31:0] wiper;
  logic        shdn;
  logic        write_in_progress_flag;
  logic [7:0]  wv [0:3]; // Expected wipers.
  logic [7:0]  st [0:6]; // Expected stored bytes.
  logic [7:0]  rnd [0:3];
  logic        volatile_select_bit;
  logic        busy;
  logic [8:0]  exp_q [$]; // Expected slot level and byte.
  int          errors;
  int          n_checks;
  assign sda = ~(sda_pull | (sda_oe_o & ~sda_o));
  initial ref_clk_i = 1'b0;
  always #4 ref_clk_i = ~ref_clk_i;
  potsa_core #(.NV_WR_CYC(NV)) potsa_core_inst (.ref_clk_i, .sys_rst_i, .scl_i(scl), .sda_i(sda), .sda_o,
    .sda_oe_o, .addr_select_pin_2_i(pins[2]), .addr_select_pin_1_i(pins[1]), .addr_select_pin_0_i(pins[0]),
    .wiper_o(wiper), .shutdown_bit_o(shdn), .write_in_progress_flag_o(write_in_progress_flag));
  potsa_ctrl_model potsa_ctrl_model_inst (.ref_clk_i, .sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] id(input logic rd);
    return {potsa_pkg::POTSA_ID_PREFIX, pins, rd};
  endfunction
  // Expected content of one location.
  function automatic logic [7:0] peek(input logic [7:0] a);
    if (a == 8'h08)
      return {volatile_select_bit, 1'b1, busy, 5'h00};
    if (a <= 8'h03 && volatile_select_bit)
      return wv[a[1:0]];
    if (a <= 8'h06)
      return st[a[2:0]];
    return 8'h00;
  endfunction
  task automatic put(input logic [7:0] b, input logic nak);
    exp_q.push_back({nak, b});
    potsa_ctrl_model_inst.byte_x(b, 1'b1);
  endtask
  task automatic get(input logic [7:0] e, input logic last);
    exp_q.push_back({last, e});
    potsa_ctrl_model_inst.byte_x(8'hFF, last);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    potsa_ctrl_model_inst.start_c();
    put(id(1'b0), 1'b0);
    put(a, 1'b0);
    potsa_ctrl_model_inst.restart_c();
    put(id(1'b1), 1'b0);
    for (int k = 0; k < n; k++)
    begin
      get(peek(a), k == n - 1);
      a = (a == 8'h08) ? 8'h00 : a + 8'h01;
    end
    potsa_ctrl_model_inst.stop_c();
  endtask
  // Wiper and control writes while busy are acknowledged but dropped.
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
    potsa_ctrl_model_inst.start_c();
    put(id(1'b0), 1'b0);
    put(a, 1'b0);
    foreach (d[k])
    begin
      put(d[k], 1'b0);
      if (a == 8'h08 && !busy) volatile_select_bit = d[k][7];
      if (a <= 8'h03 && !busy) wv[a[1:0]] = d[k];
      if (a <= 8'h06 && !volatile_select_bit) st[a[2:0]] = d[k];
      a = (a == 8'h08) ? 8'h00 : a + 8'h01;
    end
    potsa_ctrl_model_inst.stop_c();
  endtask
  task automatic wait_wip(input logic v, input int lim);
    for (int k = 0; k < lim && write_in_progress_flag !== v; k++)
      @(negedge ref_clk_i);
    check({31'h0, write_in_progress_flag}, {31'h0, v});
  endtask
  // Results checked in order against the notes.
  initial
    forever
    begin
      @(potsa_ctrl_model_inst.done_ev);
      check({23'h0, potsa_ctrl_model_inst.ak_q, potsa_ctrl_model_inst.rx_q}, {23'h0, exp_q.pop_front()});
    end
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    errors++;
    give_verdict();
  end
  initial
  begin
    errors = 0;
    n_checks = 0;
    sys_rst_i = 1'b1;
    void'($urandom(32'hFF0740F4));
    pins = 3'($urandom);
    foreach (rnd[k]) rnd[k] = 8'($urandom_range(127));
    volatile_select_bit = 1'b0;
    busy = 1'b0;
    foreach (wv[k]) wv[k] = potsa_pkg::POTSA_WIPER_RST;
    foreach (st[k]) st[k] = potsa_pkg::POTSA_NV_RST;
    repeat (20) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check({30'h0, shdn, write_in_progress_flag}, 32'h2);
    rd(8'h08, 10);
    wr(8'h08, '{8'hC0, rnd[0], rnd[1], rnd[2]});
    repeat (4) @(negedge ref_clk_i);
    check(wiper, {wv[3], wv[2], wv[1], wv[0]});
    check({31'h0, write_in_progress_flag}, 32'h0);
    rd(8'h00, 4);
    wr(8'h08, '{8'h40});
    wr(8'h01, '{rnd[3]});
    wait_wip(1'b1, 100);
    busy = 1'b1;
    check({24'h0, wiper[15:8]}, {24'h0, rnd[3]});
    wr(8'h08, '{8'hC0});
    rd(8'h08, 1);
    wait_wip(1'b0, 2 * NV);
    busy = 1'b0;
    rd(8'h08, 1);
    rd(8'h01, 1);
    potsa_ctrl_model_inst.start_c();
    put(id(1'b0) ^ 8'h02, 1'b1);
    put(8'h00, 1'b1);
    potsa_ctrl_model_inst.stop_c();
    rd(8'h00, 1);
    give_verdict();
  end
endmodule
